/* hw/lsb_alu.sv */
`timescale 1ns/100ps
`include "lsb_consts.svh"

module lsb_alu (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              arst_n,
  // Request from decoder and register file
  input  wire logic              req_valid,
  input  wire lsb_pkg::lsb_req_t req,
  // Result towards write-back
  output lsb_pkg::lsb_res_t      res
);
  import lsb_pkg::*;

  lsb_state_t  st_reg;
  lsb_state_t  st_next;
  logic [31:0] mask;
  logic [31:0] opnd_b;
  logic [31:0] val;
  logic [4:0]  count;
  logic [2:0]  bit_idx;
  logic [7:0]  bit_mask;
  logic        is_shift;
  logic        is_small;
  logic        fixed_ok;
  logic        small_ok;
  logic        cond_ok;
  logic        err;
  logic [31:0] sh_result;
  logic        sh_c;

  lsb_shift_unit u_shift (
    .operand (req.dst),
    .size    (req.size),
    .op      (req.op),
    .count   (count),
    .c_in    (req.c_in),
    .result  (sh_result),
    .c_out   (sh_c)
  );

  always_comb begin
    if (req.size == LSB_SZ_BYTE) begin
      mask = `LSB_MASK_BYTE;
    end else if (req.size == LSB_SZ_WORD) begin
      mask = `LSB_MASK_WORD;
    end else begin
      mask = `LSB_MASK_LONG;
    end
    opnd_b   = req.use_imm ? req.immediate_value : req.source_operand;
    count    = req.count_from_reg ? req.source_operand[4:0] : req.count_imm;
    bit_idx  = req.bit_from_reg ? req.source_operand[2:0] : req.bit_imm;
    bit_mask = 8'h01 << bit_idx;
    is_shift = req.op inside {LSB_OP_LSL, LSB_OP_LSR, LSB_OP_ASL, LSB_OP_ASR,
                              LSB_OP_ROL, LSB_OP_ROR, LSB_OP_ROXL, LSB_OP_ROXR};
    is_small = is_shift && !(req.op inside {LSB_OP_LSL, LSB_OP_LSR});
    fixed_ok = count inside {`LSB_DIST_1, `LSB_DIST_2, `LSB_DIST_4, `LSB_DIST_8, `LSB_DIST_16};
    small_ok = count inside {`LSB_DIST_1, `LSB_DIST_2};
    cond_ok  = (req.z_in == req.cond_zero_set);
    err      = 1'b0;
    if (is_small && !small_ok) begin
      err = 1'b1;
    end else if (is_shift && req.dst_in_mem && !fixed_ok) begin
      err = 1'b1;
    end else if (req.op == LSB_OP_BSETCC && !req.dst_in_mem) begin
      err = 1'b1;
    end else if (req.op == LSB_OP_NOP) begin
      err = 1'b1;
    end
    val = req.dst;
    case (req.op)
      LSB_OP_AND: begin
        val = (req.dst & ~mask) | (req.dst & opnd_b & mask);
      end
      LSB_OP_OR: begin
        val = (req.dst & ~mask) | ((req.dst | opnd_b) & mask);
      end
      LSB_OP_XOR: begin
        val = (req.dst & ~mask) | ((req.dst ^ opnd_b) & mask);
      end
      LSB_OP_NOT: begin
        val = (req.dst & ~mask) | (~req.dst & mask);
      end
      LSB_OP_BITSET: begin
        val = {req.dst[31:8], req.dst[7:0] | bit_mask};
      end
      LSB_OP_BITCLR: begin
        val = {req.dst[31:8], req.dst[7:0] & ~bit_mask};
      end
      LSB_OP_BSETCC: begin
        val = {req.dst[31:8], req.dst[7:0] | (cond_ok ? bit_mask : 8'h00)};
      end
      default: begin
        if (is_shift) begin
          val = (req.dst & ~mask) | sh_result;
        end
      end
    endcase

    st_next           = st_reg;
    st_next.res.valid = 1'b0;
    if (req_valid) begin
      st_next.res.valid    = 1'b1;
      st_next.res.error    = err;
      st_next.res.write_en = !err;
      st_next.res.data     = err ? req.dst : val;
      st_next.res.c_out    = (is_shift && !err) ? sh_c : req.c_in;
      st_next.res.z_out    = ((val & mask) == 32'h0000_0000);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{res: '{valid: 1'b0, write_en: 1'b0, error: 1'b0, c_out: 1'b0,
                         z_out: 1'b0, data: `LSB_RST_DATA}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign res = st_reg.res;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  logic go;
  assign go = req_valid && !err;

  chk_valid_pulse: assert property (req_valid |=> res.valid && $past(!res.valid || req_valid))
    else $error("result valid not one cycle after request");
  chk_and_byte: assert property (
    go && req.op == LSB_OP_AND && req.size == LSB_SZ_BYTE |=>
    res.data == {$past(req.dst[31:8]), $past(req.dst[7:0] & opnd_b[7:0])})
    else $error("byte and result wrong");
  chk_or_long: assert property (
    go && req.op == LSB_OP_OR && req.size == LSB_SZ_LONG |=> res.data == $past(req.dst | opnd_b))
    else $error("long or result wrong");
  chk_xor_word: assert property (
    go && req.op == LSB_OP_XOR && req.size == LSB_SZ_WORD |=>
    res.data[15:0] == $past(req.dst[15:0] ^ opnd_b[15:0]) && res.data[31:16] == $past(req.dst[31:16]))
    else $error("word xor result wrong");
  chk_not_byte: assert property (
    go && req.op == LSB_OP_NOT && req.size == LSB_SZ_BYTE |=> res.data[7:0] == ~$past(req.dst[7:0]))
    else $error("byte complement wrong");
  chk_lsl_long: assert property (
    go && req.op == LSB_OP_LSL && req.size == LSB_SZ_LONG && count == 5'h03 |=>
    res.data == $past(req.dst << 3) && res.c_out == $past(req.dst[29]))
    else $error("long shift left by three wrong");
  chk_asr_byte: assert property (
    go && req.op == LSB_OP_ASR && req.size == LSB_SZ_BYTE && count == 5'h01 |=>
    res.data[7:0] == {$past(req.dst[7]), $past(req.dst[7:1])} && res.c_out == $past(req.dst[0]))
    else $error("byte arithmetic right shift wrong");
  chk_rol_byte: assert property (
    go && req.op == LSB_OP_ROL && req.size == LSB_SZ_BYTE && count == 5'h01 |=>
    res.data[7:0] == {$past(req.dst[6:0]), $past(req.dst[7])})
    else $error("byte rotate left wrong");
  chk_roxr_byte: assert property (
    go && req.op == LSB_OP_ROXR && req.size == LSB_SZ_BYTE && count == 5'h01 |=>
    res.data[7:0] == {$past(req.c_in), $past(req.dst[7:1])} && res.c_out == $past(req.dst[0]))
    else $error("byte rotate through carry wrong");
  chk_set_bit: assert property (
    go && req.op == LSB_OP_BITSET |=> res.data[7:0] == $past(req.dst[7:0] | bit_mask))
    else $error("bit set wrong");
  chk_clr_bit: assert property (
    go && req.op == LSB_OP_BITCLR |=> res.data[7:0] == $past(req.dst[7:0] & ~bit_mask))
    else $error("bit clear wrong");
  chk_bsetcc_hold: assert property (
    go && req.op == LSB_OP_BSETCC && req.z_in != req.cond_zero_set |=>
    res.data == $past(req.dst))
    else $error("conditional bit set changed byte");
  chk_mem_dist: assert property (
    req_valid && req.op == LSB_OP_LSR && req.dst_in_mem && count == 5'h03 |=>
    res.error && !res.write_en)
    else $error("illegal memory shift distance accepted");
  chk_arith_two: assert property (
    req_valid && req.op == LSB_OP_ASL && count == 5'h03 |=> res.error)
    else $error("arithmetic shift by three accepted");

  cov_shift16: cover property (go && req.op == LSB_OP_LSR && req.dst_in_mem && count == 5'h10);
  cov_bsetcc_true: cover property (go && req.op == LSB_OP_BSETCC && cond_ok);
  cov_roxl_word: cover property (go && req.op == LSB_OP_ROXL && req.size == LSB_SZ_WORD);
  cov_back2back: cover property (req_valid ##1 req_valid);

endmodule // lsb_alu

/* hw/lsb_consts.svh */
`ifndef LSB_CONSTS_SVH
`define LSB_CONSTS_SVH

// Operand size masks
`define LSB_MASK_BYTE 32'h0000_00ff
`define LSB_MASK_WORD 32'h0000_ffff
`define LSB_MASK_LONG 32'hffff_ffff

// Most significant bit index per size
`define LSB_MSB_BYTE 5'h07
`define LSB_MSB_WORD 5'h0f
`define LSB_MSB_LONG 5'h1f

// Reset values
`define LSB_RST_DATA 32'h0000_0000

// Shift distances allowed on a memory operand; 4, 8 and 16 for LSL and LSR only
`define LSB_DIST_1  5'h01
`define LSB_DIST_2  5'h02
`define LSB_DIST_4  5'h04
`define LSB_DIST_8  5'h08
`define LSB_DIST_16 5'h10

`endif

/* hw/lsb_pkg.sv */
package lsb_pkg;

  typedef enum logic [3:0] {
    LSB_OP_AND    = 4'h0,
    LSB_OP_OR     = 4'h1,
    LSB_OP_XOR    = 4'h2,
    LSB_OP_NOT    = 4'h3,
    LSB_OP_LSL    = 4'h4,
    LSB_OP_LSR    = 4'h5,
    LSB_OP_ASL    = 4'h6,
    LSB_OP_ASR    = 4'h7,
    LSB_OP_ROL    = 4'h8,
    LSB_OP_ROR    = 4'h9,
    LSB_OP_ROXL   = 4'ha,
    LSB_OP_ROXR   = 4'hb,
    LSB_OP_BITSET = 4'hc,
    LSB_OP_BITCLR = 4'hd,
    LSB_OP_BSETCC = 4'he,
    LSB_OP_NOP    = 4'hf
  } lsb_op_t;

  typedef enum logic [1:0] {
    LSB_SZ_BYTE = 2'h0,
    LSB_SZ_WORD = 2'h1,
    LSB_SZ_LONG = 2'h2
  } lsb_size_t;

  typedef struct packed {
    lsb_op_t     op;
    lsb_size_t   size;
    logic [31:0] dst;
    logic [31:0] source_operand;
    logic [31:0] immediate_value;
    logic        use_imm;
    logic [4:0]  count_imm;
    logic        count_from_reg;
    logic [2:0]  bit_imm;
    logic        bit_from_reg;
    logic        dst_in_mem;
    logic        cond_zero_set;
    logic        z_in;
    logic        c_in;
  } lsb_req_t;

  typedef struct packed {
    logic        valid;
    logic        write_en;
    logic        error;
    logic        c_out;
    logic        z_out;
    logic [31:0] data;
  } lsb_res_t;

  typedef struct packed {
    lsb_res_t res;
  } lsb_state_t;

endpackage

/* hw/lsb_shift_unit.sv */
`timescale 1ns/100ps
`include "lsb_consts.svh"

module lsb_shift_unit (
  // Operand
  input  wire logic [31:0]     operand,
  input  wire lsb_pkg::lsb_size_t size,
  input  wire lsb_pkg::lsb_op_t   op,
  input  wire logic [4:0]      count,
  input  wire logic            c_in,
  // Result, low size bits only
  output logic      [31:0]     result,
  output logic                 c_out
);
  import lsb_pkg::*;

  logic [31:0] mask;
  logic [4:0]  msb;
  logic [32:0] acc;

  // One position of movement, carry takes the bit leaving the operand
  function automatic logic [32:0] step(logic [31:0] v, logic c, lsb_op_t o,
                                       logic [4:0] m, logic [31:0] mk);
    logic [31:0] n;
    logic        nc;
    logic        fill;
    n    = 32'h0000_0000;
    nc   = 1'b0;
    fill = 1'b0;
    if (o == LSB_OP_LSL || o == LSB_OP_ASL || o == LSB_OP_ROL || o == LSB_OP_ROXL) begin
      nc = v[m];
      if (o == LSB_OP_ROL) begin
        fill = v[m];
      end else if (o == LSB_OP_ROXL) begin
        fill = c;
      end
      n = ((v << 1) | {31'h0000_0000, fill}) & mk;
    end else begin
      nc = v[0];
      if (o == LSB_OP_ASR) begin
        fill = v[m];
      end else if (o == LSB_OP_ROR) begin
        fill = v[0];
      end else if (o == LSB_OP_ROXR) begin
        fill = c;
      end
      n = (v >> 1) | (fill ? (32'h0000_0001 << m) : 32'h0000_0000);
    end
    return {nc, n};
  endfunction

  always_comb begin
    if (size == LSB_SZ_BYTE) begin
      mask = `LSB_MASK_BYTE;
      msb  = `LSB_MSB_BYTE;
    end else if (size == LSB_SZ_WORD) begin
      mask = `LSB_MASK_WORD;
      msb  = `LSB_MSB_WORD;
    end else begin
      mask = `LSB_MASK_LONG;
      msb  = `LSB_MSB_LONG;
    end
    acc = {c_in, operand & mask};
    for (int i = 0; i < 32; i++) begin
      if (5'(i) < count) begin
        acc = step(acc[31:0], acc[32], op, msb, mask);
      end
    end
    result = acc[31:0];
    c_out  = acc[32];
  end

endmodule // lsb_shift_unit

/* tb/lsb_dec_model.sv */
`timescale 1ns/100ps

module lsb_dec_model (
  // Clock
  input  wire logic         clock,
  // Request towards the datapath
  output logic              req_valid,
  output lsb_pkg::lsb_req_t req
);
  import lsb_pkg::*;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // Present a request just after an edge and keep it up
  task automatic send(input lsb_req_t r);
    @(posedge clock);
    #1;
    req_valid = 1'b1;
    req       = r;
  endtask

  // Withdraw the request; stale fields are scrambled
  task automatic idle();
    @(posedge clock);
    #1;
    req_valid = 1'b0;
    req       = ~req;
  endtask
endmodule // lsb_dec_model

/* tb/tb_top.sv */
`timescale 1ns/100ps
`include "lsb_consts.svh"

module tb_top;
  import lsb_pkg::*;

  typedef struct packed {
    lsb_op_t     op;
    lsb_size_t   size;
    logic [1:0]  inb;
    logic [4:0]  cnt;
    logic [31:0] dst;
    logic [31:0] b;
    logic [31:0] data;
    logic [1:0]  outb;
  } lsb_row_t;

  logic        clock;
  logic        arst_n;
  logic        req_valid;
  lsb_req_t    req;
  lsb_res_t    res;
  int          err_total;
  int          n_tests;
  int          cycles;
  lsb_req_t    r;
  lsb_row_t    rows [19];

  lsb_alu i_lsb_alu (
    .clock     (clock),
    .arst_n    (arst_n),
    .req_valid (req_valid),
    .req       (req),
    .res       (res)
  );

  lsb_dec_model i_lsb_dec_model (
    .clock     (clock),
    .req_valid (req_valid),
    .req       (req)
  );

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 500) begin
      err_total++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  // Flags, zero flag from the size-masked value, then data
  task automatic chk_res(input lsb_size_t sz, input logic [31:0] d, input logic [1:0] o);
    logic [31:0] m;
    m = (sz == LSB_SZ_BYTE) ? `LSB_MASK_BYTE :
        (sz == LSB_SZ_WORD) ? `LSB_MASK_WORD : `LSB_MASK_LONG;
    chk({27'h0, res.valid, res.write_en, res.error, res.c_out, res.z_out},
        {27'h0, 1'b1, ~o[0], o[0], o[1], (d & m) == 32'h0});
    chk(res.data, d);
  endtask

  // Inputs: inb is {memory, carry in}; outb is {carry out, error}
  function automatic lsb_req_t mk(input lsb_row_t w);
    lsb_req_t q;
    q                 = '0;
    q.op              = w.op;
    q.size            = w.size;
    q.dst             = w.dst;
    q.source_operand  = w.b;
    q.immediate_value = ~w.b;
    q.count_imm       = w.cnt;
    q.bit_imm         = w.b[2:0];
    q.dst_in_mem      = w.inb[1];
    q.z_in            = 1'b1;
    q.c_in            = w.inb[0];
    return q;
  endfunction

  initial begin
    clock     = 1'b0;
    arst_n    = 1'b0;
    err_total = 0;
    n_tests   = 0;
    cycles    = 0;
    rows = '{
      '{LSB_OP_AND,LSB_SZ_BYTE,2'h0,5'h00,32'h123456f0,32'h0000003c,32'h12345630,2'h0},
      '{LSB_OP_OR,LSB_SZ_WORD,2'h0,5'h00,32'h12345678,32'h00000f0f,32'h12345f7f,2'h0},
      '{LSB_OP_XOR,LSB_SZ_LONG,2'h2,5'h00,32'hffff0000,32'h0f0f0f0f,32'hf0f00f0f,2'h0},
      '{LSB_OP_NOT,LSB_SZ_BYTE,2'h3,5'h00,32'h123456a5,32'h00000000,32'h1234565a,2'h2},
      '{LSB_OP_LSL,LSB_SZ_LONG,2'h2,5'h10,32'h00018001,32'h0,32'h80010000,2'h2},
      '{LSB_OP_LSR,LSB_SZ_BYTE,2'h2,5'h04,32'h000000f8,32'h0,32'h0000000f,2'h2},
      '{LSB_OP_LSL,LSB_SZ_WORD,2'h0,5'h05,32'h00000c01,32'h0,32'h00008020,2'h2},
      '{LSB_OP_ASR,LSB_SZ_BYTE,2'h0,5'h02,32'h00000085,32'h0,32'h000000e1,2'h0},
      '{LSB_OP_ASL,LSB_SZ_WORD,2'h2,5'h01,32'h0000c001,32'h0,32'h00008002,2'h2},
      '{LSB_OP_ROL,LSB_SZ_BYTE,2'h0,5'h01,32'h00000081,32'h0,32'h00000003,2'h2},
      '{LSB_OP_ROR,LSB_SZ_LONG,2'h0,5'h02,32'h00000001,32'h0,32'h40000000,2'h0},
      '{LSB_OP_ROXL,LSB_SZ_BYTE,2'h0,5'h02,32'h000000c0,32'h0,32'h00000001,2'h2},
      '{LSB_OP_ROXR,LSB_SZ_WORD,2'h3,5'h02,32'h00000003,32'h0,32'h0000c000,2'h2},
      '{LSB_OP_BITSET,LSB_SZ_BYTE,2'h0,5'h00,32'h12345600,32'h7,32'h12345680,2'h0},
      '{LSB_OP_BITCLR,LSB_SZ_BYTE,2'h3,5'h00,32'h000000ff,32'h0,32'h000000fe,2'h2},
      '{LSB_OP_ASR,LSB_SZ_BYTE,2'h1,5'h03,32'h00000085,32'h0,32'h00000085,2'h3},
      '{LSB_OP_LSL,LSB_SZ_LONG,2'h2,5'h03,32'h00000001,32'h0,32'h00000001,2'h1},
      '{LSB_OP_NOP,LSB_SZ_LONG,2'h0,5'h00,32'h0000abcd,32'h0,32'h0000abcd,2'h1},
      '{LSB_OP_LSR,LSB_SZ_LONG,2'h1,5'h00,32'h00001234,32'h0,32'h00001234,2'h2}
    };
    repeat (5) @(posedge clock);
    #1;
    chk(res.data | {27'h0, res[36:32]}, 32'h0);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      i_lsb_dec_model.send(mk(rows[i]));
      i_lsb_dec_model.idle();
      chk_res(rows[i].size, rows[i].data, rows[i].outb);
    end
    // Immediate operand, then the result must stand
    r = mk('{LSB_OP_AND,LSB_SZ_LONG,2'h0,5'h00,32'hf0f0f0f0,32'h0ff00ff0,32'h0,2'h0});
    r.use_imm = 1'b1;
    i_lsb_dec_model.send(r);
    i_lsb_dec_model.idle();
    chk_res(LSB_SZ_LONG, 32'hf000f000, 2'h0);
    @(posedge clock);
    #1;
    chk({res.data[31:1], res.valid}, 32'hf000f000);
    // Shift distance from a register
    r = mk('{LSB_OP_LSR,LSB_SZ_LONG,2'h0,5'h00,32'hc0000000,32'hffffffff,32'h0,2'h0});
    r.count_from_reg = 1'b1;
    i_lsb_dec_model.send(r);
    i_lsb_dec_model.idle();
    chk_res(LSB_SZ_LONG, 32'h00000001, 2'h2);
    // Bit index from a register
    r = mk('{LSB_OP_BITCLR,LSB_SZ_BYTE,2'h0,5'h00,32'h000000ff,32'h13,32'h0,2'h0});
    r.bit_imm      = 3'h0;
    r.bit_from_reg = 1'b1;
    i_lsb_dec_model.send(r);
    i_lsb_dec_model.idle();
    chk_res(LSB_SZ_BYTE, 32'h000000f7, 2'h0);
    // Conditional set back to back: true, false, register destination
    r = mk('{LSB_OP_BSETCC,LSB_SZ_BYTE,2'h2,5'h00,32'h0,32'h5,32'h0,2'h0});
    r.bit_imm       = 3'h0;
    r.bit_from_reg  = 1'b1;
    r.cond_zero_set = 1'b1;
    i_lsb_dec_model.send(r);
    r.z_in = 1'b0;
    r.dst  = 32'h00000011;
    i_lsb_dec_model.send(r);
    chk_res(LSB_SZ_BYTE, 32'h00000020, 2'h0);
    r.z_in       = 1'b1;
    r.dst_in_mem = 1'b0;
    i_lsb_dec_model.send(r);
    chk_res(LSB_SZ_BYTE, 32'h00000011, 2'h0);
    i_lsb_dec_model.idle();
    chk_res(LSB_SZ_BYTE, 32'h00000011, 2'h1);
    @(posedge clock);
    #1;
    chk({res.data[31:1], res.valid}, 32'h00000010);
    // Reset in mid-run clears the result at once
    arst_n = 1'b0;
    #1;
    chk(res.data | {27'h0, res[36:32]}, 32'h0);
    end_sim();
  end
endmodule // tb_top
